//--- verilog/afss_cfg.svh
`ifndef AFSS_CFG_SVH
`define AFSS_CFG_SVH
// malfunction output delay after power-on, in ms
`define AFSS_ALM_ON_MS 1500
// cycles per ms at 125 MHz
`define AFSS_CYC_PER_MS 125000
`define AFSS_ALM_ON_CYC (`AFSS_ALM_ON_MS * `AFSS_CYC_PER_MS)
// default main circuit charge time, in cycles
`define AFSS_CHARGE_CYC 1000000
`define AFSS_CNT_W 28
`define AFSS_ZERO_CNT 28'h0000000
`define AFSS_ONE_CNT 28'h0000001
`endif

//--- verilog/afss_pkg.sv
package afss_pkg;
	typedef enum logic [2:0] {
		AFSS_ST_STARTUP,
		AFSS_ST_CHARGE,
		AFSS_ST_READY,
		AFSS_ST_STOPPED
	} afss_state_t;

	// alarm causes and clear requests from the units
	typedef struct packed {
		logic conv_cause;
		logic drive_cause;
		logic conv_power_cycle;
		logic drive_power_cycle;
		logic confirm_button;
		logic fault_reset;
		logic err_reset_cmd;
		logic cpu_reset_cmd;
	} afss_req_t;

	// latched status bits
	typedef struct packed {
		logic conv_alarm;
		logic drive_alarm;
		logic main_power_off_warning;
	} afss_stat_t;
endpackage : afss_pkg

//--- verilog/afss_timer.sv
`timescale 1ns/1ns
`include "afss_cfg.svh"
// ----------------------------------------
// up counter, done when COUNT cycles reached
// ----------------------------------------
module afss_timer #(
	parameter logic [`AFSS_CNT_W-1:0] COUNT = `AFSS_ONE_CNT
) (
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // sync reset, low
	input wire logic run_in, // count while high, restart when low
	output logic done_out // count reached
);
	logic [`AFSS_CNT_W-1:0] cnt_reg;
	logic [`AFSS_CNT_W-1:0] cnt_next;
	logic done_next;

	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (!run_in) begin
			cnt_next = `AFSS_ZERO_CNT;
		end else if (cnt_reg >= COUNT - `AFSS_ONE_CNT) begin
			done_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + `AFSS_ONE_CNT;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cnt_reg <= `AFSS_ZERO_CNT;
			done_out <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_out <= done_next;
		end
	end
endmodule : afss_timer

//--- verilog/afss_alarm_latch.sv
`timescale 1ns/1ns
// ----------------------------------------
// sticky alarm; clear only without cause
// ----------------------------------------
module afss_alarm_latch (
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // sync reset, low
	input wire logic set_in, // raise alarm
	input wire logic cause_in, // cause still present
	input wire logic clear_in, // clear request
	output logic alarm_out // latched alarm
);
	logic alarm_next;

	always_comb begin
		alarm_next = alarm_out;
		// set wins, and a live cause blocks the clear
		if (set_in) begin
			alarm_next = 1'b1;
		end else if (clear_in && !cause_in) begin
			alarm_next = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			alarm_out <= 1'b0;
		end else begin
			alarm_out <= alarm_next;
		end
	end
endmodule : afss_alarm_latch

//--- verilog/afss_sequencer.sv
`timescale 1ns/1ns
`include "afss_cfg.svh"
// Function
// RULE1: contactor-enabled mode: converter alarm opens contactor, drive stops.
// RULE2: clear requests ignored while the alarm cause remains.
// RULE3: drive in servo-off ignores converter alarm, raises none.
// RULE4: converter alarm during servo-on alarms drive and forces servo-off.
// RULE5: general variant: clearing drive alarm also clears converter alarm.
// RULE6: drive alarm disables power stage, fires external dynamic brake.
// RULE7: general drive alarm clear: power cycle, confirm button, fault reset.
// RULE8: networked drive alarm clear: power cycle, error or processor reset.
// RULE9: networked converter alarm clear: power cycle or servo-on command.
// RULE10: main power only after start-up and with no alarms.
// RULE11: contactor-disabled mode: alarm forces servo-off, supply stays connected.
// RULE12: outside sequence removes supply on any alarm in disabled mode.
// RULE13: outside resumes: clear converter, clear drive, then reset.
// RULE14: outside reapplies supply only with drive alarm cleared.
// RULE15: forced stop opens contactor, stops drive, raises power-off warning.
// RULE16: forced stop release closes contactor and resumes without reset.
// RULE17: power stage and brake interlock wait for full capacitor charge. Disabled mode skips the charge wait when resuming from STOPPED.
// RULE18: outside brake released while interlock on, engaged while off.
// RULE19: disabled mode forced stop: stage off, warning, power kept.
// RULE20: forced stop release clears the main-power-off warning.
// RULE21: outside allows about 50 ms dynamic brake delay.
// RULE22: forced stop input is active low.
// RULE23: malfunction output on 1.5 s after power-on without alarm.
// RULE24: static setting selects contactor-enabled or disabled behaviour.
// RULE25: converter alarm, drive alarm, warning held as separate bits.
module afss_sequencer #(
	parameter logic [`AFSS_CNT_W-1:0] ALM_ON_CYC = `AFSS_CNT_W'(`AFSS_ALM_ON_CYC),
	parameter logic [`AFSS_CNT_W-1:0] CHARGE_CYC = `AFSS_CNT_W'(`AFSS_CHARGE_CYC)
) (
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // sync reset, low
	input wire logic contactor_en_in, // static: contactor output enabled
	input wire logic networked_in, // static: networked variant
	input wire logic startup_done_in, // drive start-up complete
	input wire logic servo_on_cmd_in, // servo-on command
	input wire logic forced_stop_input_b_in, // forced stop, low active
	input afss_pkg::afss_req_t req_in, // causes and clear requests
	output logic contactor_out, // main contactor coil drive
	output logic power_stage_out, // drive power stage enable
	output logic servo_on_out, // drive servo-on state
	output logic dyn_brake_out, // external dynamic brake active
	output logic brake_interlock_output_out, // brake released when high
	output logic malfunction_output_out, // high when healthy
	output afss_pkg::afss_stat_t stat_out // latched status bits
);
	import afss_pkg::*;

	// ----------------------------------------
	// alarm latches
	// ----------------------------------------
	logic conv_alarm;
	logic drive_alarm;
	logic conv_set;
	logic drive_set;
	logic conv_clear;
	logic drive_clear;
	logic drive_clear_gp;
	logic drive_clear_net;
	logic servo_on_reg;
	logic servo_on_next;
	logic warn_reg;
	logic warn_next;
	logic forced_stop;

	assign forced_stop = !forced_stop_input_b_in; // RULE22
	assign conv_set = req_in.conv_cause;
	// converter alarm propagates only while servo-on
	assign drive_set = req_in.drive_cause || (req_in.conv_cause && servo_on_reg); // RULE3 RULE4
	assign drive_clear_gp = req_in.drive_power_cycle || req_in.confirm_button
		|| req_in.fault_reset; // RULE7
	assign drive_clear_net = req_in.drive_power_cycle || req_in.err_reset_cmd
		|| req_in.cpu_reset_cmd; // RULE8
	assign drive_clear = networked_in ? drive_clear_net : drive_clear_gp;

	always_comb begin
		conv_clear = req_in.conv_power_cycle;
		if (networked_in) begin
			conv_clear = conv_clear || servo_on_cmd_in; // RULE9
		end else begin
			conv_clear = conv_clear || (drive_clear && drive_alarm && !req_in.drive_cause); // RULE5
		end
	end

	afss_alarm_latch u_conv_latch (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.set_in(conv_set),
		.cause_in(req_in.conv_cause), // RULE2
		.clear_in(conv_clear),
		.alarm_out(conv_alarm)
	);

	afss_alarm_latch u_drive_latch (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.set_in(drive_set),
		.cause_in(req_in.drive_cause), // RULE2
		.clear_in(drive_clear),
		.alarm_out(drive_alarm)
	);

	// ----------------------------------------
	// timers
	// ----------------------------------------
	logic alm_on_done;
	logic charge_done;
	logic charging;
	afss_state_t state_reg;
	afss_state_t state_next;

	afss_timer #(
		.COUNT(ALM_ON_CYC)
	) u_alm_timer (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.run_in(1'b1),
		.done_out(alm_on_done)
	);

	assign charging = (state_reg == AFSS_ST_CHARGE);

	afss_timer #(
		.COUNT(CHARGE_CYC)
	) u_charge_timer (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.run_in(charging),
		.done_out(charge_done)
	);

	// ----------------------------------------
	// power sequence
	// ----------------------------------------
	logic any_alarm;
	logic contactor_next;
	logic stage_next;
	logic dyn_next;
	logic mbr_next;
	logic alm_next;

	assign any_alarm = conv_alarm || drive_alarm || conv_set || drive_set;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			AFSS_ST_STARTUP: begin
				if (startup_done_in && !any_alarm && !forced_stop) begin
					state_next = AFSS_ST_CHARGE; // RULE10
				end
			end
			AFSS_ST_CHARGE: begin
				if (any_alarm || forced_stop) begin
					state_next = AFSS_ST_STOPPED;
				end else if (charge_done) begin
					state_next = AFSS_ST_READY; // RULE17
				end
			end
			AFSS_ST_READY: begin
				if (any_alarm || forced_stop) begin
					state_next = AFSS_ST_STOPPED; // RULE1 RULE15 RULE19
				end
			end
			AFSS_ST_STOPPED: begin
				// resumes on its own once stop and alarms are gone
				if (!any_alarm && !forced_stop) begin
					state_next = contactor_en_in ? AFSS_ST_CHARGE : AFSS_ST_READY; // RULE16
				end
			end
			default: begin
				state_next = AFSS_ST_STARTUP;
			end
		endcase
	end

	always_comb begin
		// contactor follows the sequence only in enabled mode
		if (contactor_en_in) begin
			contactor_next = (state_next == AFSS_ST_CHARGE)
				|| (state_next == AFSS_ST_READY); // RULE1 RULE15 RULE16 RULE24
		end else begin
			contactor_next = 1'b0; // RULE11 RULE24
		end
		stage_next = (state_next == AFSS_ST_READY) && !any_alarm; // RULE6 RULE11 RULE17
		servo_on_next = stage_next && servo_on_cmd_in; // RULE4 RULE11
		dyn_next = drive_alarm || drive_set; // RULE6
		mbr_next = stage_next; // RULE17
		alm_next = alm_on_done && !any_alarm; // RULE23
		warn_next = warn_reg;
		if (forced_stop && (state_reg != AFSS_ST_STARTUP)) begin
			warn_next = 1'b1; // RULE15 RULE19
		end else if (!forced_stop) begin
			warn_next = 1'b0; // RULE20
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_reg <= AFSS_ST_STARTUP;
			contactor_out <= 1'b0;
			power_stage_out <= 1'b0;
			servo_on_reg <= 1'b0;
			dyn_brake_out <= 1'b0;
			brake_interlock_output_out <= 1'b0;
			malfunction_output_out <= 1'b0;
			warn_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			contactor_out <= contactor_next;
			power_stage_out <= stage_next;
			servo_on_reg <= servo_on_next;
			dyn_brake_out <= dyn_next;
			brake_interlock_output_out <= mbr_next;
			malfunction_output_out <= alm_next;
			warn_reg <= warn_next;
		end
	end

	assign servo_on_out = servo_on_reg;
	assign stat_out.conv_alarm = conv_alarm; // RULE25
	assign stat_out.drive_alarm = drive_alarm; // RULE25
	assign stat_out.main_power_off_warning = warn_reg; // RULE25
endmodule : afss_sequencer

//--- bench/afss_sequencer_properties.sv
`timescale 1ns/1ns
// --
// sequencer checks
// --
module afss_sequencer_properties #(
	parameter logic [27:0] ALM_ON_CYC = 28'h0000001,
	parameter logic [27:0] CHARGE_CYC = 28'h0000001
) (
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // reset
	input wire logic contactor_en_in, // mode
	input wire logic startup_done_in, // start-up done
	input wire logic forced_stop_input_b_in, // forced stop
	input afss_pkg::afss_req_t req_in, // requests
	input wire logic contactor_out, // contactor
	input wire logic power_stage_out, // stage
	input wire logic servo_on_out, // servo
	input wire logic dyn_brake_out, // brake
	input wire logic brake_interlock_output_out, // interlock
	input wire logic malfunction_output_out, // healthy
	input afss_pkg::afss_stat_t stat_out // status
);
	import afss_pkg::*;
	logic [27:0] up_reg;
	logic [27:0] up_next;
	always_comb up_next = (up_reg == ALM_ON_CYC) ? up_reg : up_reg + 28'h0000001;
	always_ff @(posedge clk_in) up_reg <= rst_b_in ? up_next : 28'h0000000;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	conv_stop_a: assert property ($rose(stat_out.conv_alarm) && contactor_en_in |-> ##[0:2] !contactor_out)
		else $error("contactor kept on");
	servo_off_ignore_a: assert property (!servo_on_out && !stat_out.drive_alarm && !req_in.drive_cause |=> !stat_out.drive_alarm)
		else $error("drive alarm while off");
	conv_to_drive_a: assert property (servo_on_out && req_in.conv_cause |=> stat_out.drive_alarm ##[1:2] !servo_on_out)
		else $error("no drive alarm");
	drive_coast_a: assert property (stat_out.drive_alarm[*3] |-> !power_stage_out && dyn_brake_out && !servo_on_out)
		else $error("no coast");
	power_gate_a: assert property ($rose(contactor_out) |-> contactor_en_in && startup_done_in && !stat_out.conv_alarm && !stat_out.drive_alarm)
		else $error("early power");
	stop_warn_a: assert property ($fell(forced_stop_input_b_in) && power_stage_out |-> ##[1:3] stat_out.main_power_off_warning && !power_stage_out && !contactor_out)
		else $error("no forced stop");
	release_clear_a: assert property ($rose(forced_stop_input_b_in) |=> !stat_out.main_power_off_warning)
		else $error("warning kept");
	charge_wait_a: assert property ($rose(power_stage_out) && contactor_en_in |-> brake_interlock_output_out && $past(contactor_out, 8))
		else $error("stage before charge");
	healthy_delay_a: assert property (malfunction_output_out |-> up_reg == ALM_ON_CYC)
		else $error("healthy too early");
	cover property ($rose(stat_out.drive_alarm));
	cover property ($rose(stat_out.main_power_off_warning));
	cover property ($rose(malfunction_output_out));
endmodule : afss_sequencer_properties
bind afss_sequencer afss_sequencer_properties #(.ALM_ON_CYC(ALM_ON_CYC), .CHARGE_CYC(CHARGE_CYC)) i_props (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .contactor_en_in(contactor_en_in),
	.startup_done_in(startup_done_in), .forced_stop_input_b_in(forced_stop_input_b_in),
	.req_in(req_in), .contactor_out(contactor_out), .power_stage_out(power_stage_out),
	.servo_on_out(servo_on_out), .dyn_brake_out(dyn_brake_out),
	.brake_interlock_output_out(brake_interlock_output_out),
	.malfunction_output_out(malfunction_output_out), .stat_out(stat_out));

//--- bench/afss_partner.sv
`timescale 1ns/1ns
// --
// external supply and brake sequence
// --
module afss_partner (
	input wire logic contactor_en_in, // device mode
	input afss_pkg::afss_stat_t stat_in, // device alarms
	input wire logic brake_interlock_in, // interlock
	output logic supply_on_out, // main supply on
	output logic brake_engaged_out // brake engaged
);
	import afss_pkg::*;
	assign supply_on_out = contactor_en_in | !(stat_in.conv_alarm | stat_in.drive_alarm);
	// the brake's own contactor delay lies outside this model
	assign brake_engaged_out = !brake_interlock_in;
endmodule : afss_partner

//--- bench/afss_sequencer_bench.sv
`timescale 1ns/1ns
module afss_sequencer_bench;
	import afss_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic en = 1'b1;
	logic net = 1'b0;
	logic up = 1'b0;
	logic son = 1'b0;
	logic fs_b = 1'b1;
	afss_req_t req = '0;
	afss_stat_t st;
	logic con, stage, srv, dyn, brake_interlock_output, malfunction_output, supply, brk, dclr;
	logic m_conv = 1'b0;
	logic m_drive = 1'b0;
	logic [31:0] rnd = 32'h00000019;
	int mismatches = 0;
	int num_checks = 0;
	int c;
	always #4 clk_in = ~clk_in;
	afss_sequencer #(.ALM_ON_CYC(28'h0000014), .CHARGE_CYC(28'h000000a)) i_afss_sequencer (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .contactor_en_in(en), .networked_in(net),
		.startup_done_in(up), .servo_on_cmd_in(son), .forced_stop_input_b_in(fs_b), .req_in(req),
		.contactor_out(con), .power_stage_out(stage), .servo_on_out(srv), .dyn_brake_out(dyn),
		.brake_interlock_output_out(brake_interlock_output), .malfunction_output_out(malfunction_output), .stat_out(st));
	afss_partner i_afss_partner (.contactor_en_in(en), .stat_in(st), .brake_interlock_in(brake_interlock_output),
		.supply_on_out(supply), .brake_engaged_out(brk));
	// --
	// alarm latch model
	// --
	assign dclr = req.drive_power_cycle | (net ? req.err_reset_cmd | req.cpu_reset_cmd
		: req.confirm_button | req.fault_reset);
	always @(posedge clk_in) begin
		m_drive <= rst_b_in & (req.drive_cause | m_drive & !dclr);
		m_conv <= rst_b_in & (req.conv_cause | m_conv & !(req.conv_power_cycle | net & son
			| !net & dclr & m_drive & !req.drive_cause));
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic pulse(input int b);
		@(posedge clk_in) req[b] <= 1'b1;
		@(posedge clk_in) req[b] <= 1'b0;
		tick(2);
	endtask : pulse
	task automatic wait_stage;
		c = 0;
		while (stage !== 1'b1 && c < 60) begin
			tick(1);
			c++;
		end
		chk("stage", 1'b1, stage);
		if (en) chk("charge", 1'b1, c > 6);
	endtask : wait_stage
	task automatic boot(input logic e, input logic n);
		@(posedge clk_in) rst_b_in <= 1'b0;
		en <= e;
		net <= n;
		up <= 1'b0;
		son <= 1'b1;
		fs_b <= 1'b1;
		req <= '0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		tick(2);
		chk("malfunction", 1'b0, malfunction_output);
		@(posedge clk_in) up <= 1'b1;
		wait_stage();
		chk("contactor", e, con);
	endtask : boot
	task automatic try_clear(input int b);
		pulse(6);
		pulse(b);
		chk("drive alarm", !(b == 4 || (net ? b < 2 : b > 1)), st.drive_alarm);
	endtask : try_clear
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (8000) @(posedge clk_in);
		mismatches++;
		close_out();
	end
	initial begin
		boot(1'b1, 1'b0);
		tick(8);
		chk("malfunction", 1'b1, malfunction_output);
		@(posedge clk_in) fs_b <= 1'b0;
		tick(4);
		chk("contactor", 1'b0, con);
		chk("warning", 1'b1, st.main_power_off_warning);
		@(posedge clk_in) fs_b <= 1'b1;
		tick(2);
		chk("warning", 1'b0, st.main_power_off_warning);
		wait_stage();
		chk("servo", 1'b1, srv);
		chk("brake", 1'b0, brk);
		@(posedge clk_in) req.conv_cause <= 1'b1;
		tick(4);
		chk("contactor", 1'b0, con);
		chk("drive alarm", 1'b1, st.drive_alarm);
		chk("servo", 1'b0, srv);
		chk("dyn brake", 1'b1, dyn);
		pulse(5);
		chk("conv alarm", 1'b1, st.conv_alarm);
		@(posedge clk_in) req.conv_cause <= 1'b0;
		pulse(2);
		chk("conv alarm", 1'b0, st.conv_alarm);
		son <= 1'b0;
		pulse(7);
		chk("drive alarm", 1'b0, st.drive_alarm);
		for (int b = 0; b < 5; b++) try_clear(b);
		$display("test general done");
		boot(1'b1, 1'b1);
		@(posedge clk_in) req.conv_cause <= 1'b1;
		tick(4);
		@(posedge clk_in) req.conv_cause <= 1'b0;
		tick(3);
		chk("conv alarm", 1'b0, st.conv_alarm);
		chk("drive alarm", 1'b1, st.drive_alarm);
		for (int b = 0; b < 5; b++) try_clear(b);
		$display("test networked done");
		boot(1'b0, 1'b0);
		@(posedge clk_in) fs_b <= 1'b0;
		tick(4);
		chk("stage", 1'b0, stage);
		chk("warning", 1'b1, st.main_power_off_warning);
		@(posedge clk_in) fs_b <= 1'b1;
		wait_stage();
		pulse(6);
		chk("servo", 1'b0, srv);
		chk("contactor", 1'b0, con);
		chk("supply", 1'b0, supply);
		pulse(4);
		chk("supply", 1'b1, supply);
		$display("test disabled done");
		for (int k = 0; k < 2; k++) begin
			boot(1'b1, k[0]);
			@(posedge clk_in) fs_b <= 1'b0;
			tick(3);
			repeat (300) begin
				@(posedge clk_in);
				rnd = xs(rnd);
				req <= afss_req_t'({rnd[0] & rnd[1], rnd[2] & rnd[3], rnd[13:8]});
				son <= rnd[14];
				@(negedge clk_in);
				chk("conv alarm", m_conv, st.conv_alarm);
				chk("drive alarm", m_drive, st.drive_alarm);
			end
		end
		$display("test random done");
		close_out();
	end
endmodule : afss_sequencer_bench
